//--- src/fsw_pkg.sv
package fsw_pkg;

	// Opcodes handled at the link
	localparam logic [7:0] OPC_LATCH_CLEAR = 8'h04; // latch_clear_cmd
	localparam logic [7:0] OPC_STAT1_READ  = 8'h05; // status_read_cmd
	localparam logic [7:0] OPC_STAT2_RD_A  = 8'h09; // status2_read_cmd, first code
	localparam logic [7:0] OPC_STAT2_RD_B  = 8'h35; // status2_read_cmd, second code

	// First status byte fields
	localparam int BUSY_BIT      = 0; // write_busy_flag
	localparam int WEL_BIT       = 1; // write_enable_latch
	localparam int LEVEL_LO_BIT  = 2; // protect_level_lo
	localparam int LEVEL_HI_BIT  = 4; // protect_level_hi
	localparam int BOTTOM_BIT    = 5; // protect_from_bottom
	localparam int SMALL_BIT     = 6; // small_unit_lock
	localparam int LOCK_BIT      = 7; // status_lock

	// Second status byte fields
	localparam int QUAD_BIT      = 1; // quad_lines_enable
	localparam int PSUSP_BIT     = 2; // program_suspended_flag
	localparam int OTP_C_BIT     = 3; // otp_lock_c
	localparam int OTP_A_BIT     = 5; // otp_lock_a
	localparam int COMPL_BIT     = 6; // protect_complement
	localparam int ESUSP_BIT     = 7; // erase_suspended_flag

	// Reset values and write masks
	localparam logic [7:0] STAT1_RST      = 8'h00; // All protection off, latch clear
	localparam logic [7:0] STAT2_RST      = 8'h02; // Quad lines enabled by default
	localparam logic [7:0] STAT1_WR_MASK  = 8'hfc; // Bits 7..2 writable
	localparam logic [7:0] STAT2_NV_MASK  = 8'h42; // Complement and quad enable
	localparam logic [7:0] STAT2_OTP_MASK = 8'h38; // One-time lock bits

	// Link bit counts per byte
	localparam logic [2:0] LAST_SINGLE = 3'h7; // Eight clocks per byte
	localparam logic [2:0] LAST_QUAD   = 3'h1; // Two clocks per byte

	// Array operations checked against protection
	typedef enum logic [2:0] {
		FSW_OP_PAGE  = 3'h0,
		FSW_OP_QPAGE = 3'h1,
		FSW_OP_SECT  = 3'h2,
		FSW_OP_HALF  = 3'h3,
		FSW_OP_BLOCK = 3'h4,
		FSW_OP_CHIP  = 3'h5
	} fsw_op_kind_t;

	// Read selection at the link, one-hot
	typedef enum logic [2:0] {
		FSW_RD_NONE  = 3'b001,
		FSW_RD_STAT1 = 3'b010,
		FSW_RD_STAT2 = 3'b100
	} fsw_rd_sel_t;

endpackage : fsw_pkg

//--- src/fsw_status_protect.sv
`timescale 1ns/1ns
// Behaviour
// RQ1 - Latch-clear opcode frame clears write-enable latch
// RQ2 - Latch cleared at reset and operation completion
// RQ3 - First status readable at any time
// RQ4 - Status byte repeats while select stays low
// RQ5 - Host polls busy before new instructions
// RQ6 - Bit 0 shows busy cycle running
// RQ7 - Bit 1 latch; latch low rejects writes
// RQ8 - Nonzero level protects region from writes
// RQ9 - Level changes only outside hardware protection
// RQ10 - Chip erase only with level zero
// RQ11 - Bit 5 selects top or bottom
// RQ12 - Bit 6 selects block or sector unit
// RQ13 - Lock plus low protect pin freezes status
// RQ14 - Both second-status opcodes read any time
// RQ15 - Bit 7 shows erase suspended
// RQ16 - Bit 2 shows program suspended
// RQ17 - One-time lock bits set once, block writes
// RQ18 - Quad enable disables protect and hold pins
// RQ19 - Output MSB first on falling edges
// RQ20 - Four-line mode moves nibbles, two clocks/byte
module fsw_status_protect (
	input  wire logic       clk_sys_i,             // System clock
	input  wire logic       sys_rst_i,             // Synchronous reset
	input  wire logic       ce_i,                  // Clock enable, system domain
	input  wire logic       link_clk_i,            // Serial clock from host
	input  wire logic       cs_n_i,                // Chip select, active low
	input  wire logic [3:0] dq_i,                  // Data lines in, bit 0 is serial_in_pin
	output logic      [3:0] dq_o,                  // Data lines out
	output logic      [3:0] dq_oe_o,               // Data line enables
	input  wire logic       wp_n_i,                // Write-protect pin
	input  wire logic       four_line_cmd_mode_i,  // Four-line command mode
	input  wire logic       busy_i,                // Timed cycle running
	input  wire logic       erase_suspended_i,     // Erase suspended
	input  wire logic       program_suspended_i,   // Program suspended
	input  wire logic       wel_set_i,             // Latch set request
	input  wire logic       stat_wr_req_i,         // Status write request
	input  wire logic [7:0] stat_wr_data1_i,       // New first status byte
	input  wire logic [7:0] stat_wr_data2_i,       // New second status byte
	output logic            stat_wr_start_o,       // Status write accepted
	output logic            stat_wr_reject_o,      // Status write refused
	input  wire logic       op_req_i,              // Array operation request
	input  wire logic [2:0] op_kind_i,             // Operation kind
	input  wire logic       op_in_region_i,        // Target inside protected region
	input  wire logic [2:0] op_otp_hit_i,          // Target in security sector a,b,c
	output logic            op_grant_o,            // Operation allowed
	output logic            op_reject_o,           // Operation refused
	input  wire logic       op_done_i,             // Write, program or erase finished
	output logic      [7:0] stat1_o,               // First status byte
	output logic      [7:0] stat2_o,               // Second status byte
	output logic            pin_functions_en_o     // Protect and hold pins active
);

	// Stored status fields
	logic       write_enable_latch;             // write_enable_latch
	logic [5:0] stat1_nv;        // Bits 7..2 of first byte
	logic       compl_q;         // protect_complement
	logic       quad_q;          // quad_lines_enable
	logic [2:0] otp_q;           // otp_lock_c, b, a (bits 3..5)
	logic [7:0] stat1_live;      // Assembled first byte
	logic [7:0] stat2_live;      // Assembled second byte
	logic       hw_protect;      // Hardware-protected state

	// System-side synchronisers
	logic       cs_s1, cs_s2, cs_prev;   // Chip select
	logic       wp_s1, wp_s2;            // Write-protect pin
	logic       clr_s1, clr_s2, clr_prev;// Latch-clear toggle
	logic       ack_s1, ack_s2;          // Publish acknowledge
	logic       clr_pend;                // Latch-clear waits for frame end
	logic       link_rst_q;              // Reset for link toggles

	// Published copy handed to the link
	logic [7:0] pub1, pub2;      // Stable copies
	logic       pub_tgl;         // Flips when copies change

	// Link-domain state
	logic       mode_s1, mode_s2;        // Four-line mode sync
	logic       pub_s1, pub_s2;          // Publish toggle sync
	logic       ack_q;                   // Acknowledge toggle
	logic [7:0] copy1, copy2;            // Link copies of status
	logic       clr_tgl;                 // Latch-clear event toggle
	logic [6:0] in_sh;                   // Opcode shift register
	logic [2:0] in_cnt;                  // Clocks in opcode byte
	logic       op_got;                  // Opcode complete
	fsw_pkg::fsw_rd_sel_t rd_sel;        // Active read selection
	logic [7:0] next_in;                 // Opcode with current bits
	logic [2:0] last_cnt;                // Last clock index of a byte
	logic [7:0] obyte;                   // Output shift register
	logic [2:0] oidx;                    // Clock index in output byte
	logic       out_on;                  // Output driving

	// Zero level test used three times
	function automatic logic level_zero(input logic [5:0] nv);
		level_zero = (nv[2:0] == 3'h0);
	endfunction : level_zero

	// Status assembly
	always_comb begin
		stat1_live = {stat1_nv, write_enable_latch, busy_i};           // see RQ6 see RQ7 see RQ11 see RQ12
		stat2_live = {erase_suspended_i, compl_q, otp_q[2], otp_q[1], otp_q[0],
			program_suspended_i, quad_q, 1'b0};          // see RQ15 see RQ16
	end

	// Hardware protection needs lock, low pin and pin function active
	assign hw_protect = stat1_nv[5] & ~wp_s2 & ~quad_q;  // see RQ13 see RQ18
	assign pin_functions_en_o = ~quad_q;                // see RQ18
	assign stat1_o = stat1_live;
	assign stat2_o = stat2_live;

	// Two-flop synchronisers into system domain
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			cs_s1    <= 1'b1;
			cs_s2    <= 1'b1;
			cs_prev  <= 1'b1;
			wp_s1    <= 1'b1;
			wp_s2    <= 1'b1;
			clr_s1   <= 1'b0;
			clr_s2   <= 1'b0;
			clr_prev <= 1'b0;
			ack_s1   <= 1'b0;
			ack_s2   <= 1'b0;
		end else if (ce_i) begin
			cs_s1    <= cs_n_i;
			cs_s2    <= cs_s1;
			cs_prev  <= cs_s2;
			wp_s1    <= wp_n_i;
			wp_s2    <= wp_s1;
			clr_s1   <= clr_tgl;
			clr_s2   <= clr_s1;
			clr_prev <= clr_s2;
			ack_s1   <= ack_q;
			ack_s2   <= ack_s1;
		end
	end

	// Held reset for link-side toggles
	always_ff @(posedge clk_sys_i) begin
		link_rst_q <= sys_rst_i;
	end

	// Publish handshake: update only once the link has taken the last copy
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			pub1    <= fsw_pkg::STAT1_RST;
			pub2    <= fsw_pkg::STAT2_RST;
			pub_tgl <= 1'b0;
		end else if (ce_i) begin
			if ((ack_s2 == pub_tgl) && ({pub1, pub2} != {stat1_live, stat2_live})) begin
				pub1    <= stat1_live;
				pub2    <= stat2_live;
				pub_tgl <= ~pub_tgl;
			end
		end
	end

	// Latch-clear takes effect when the frame closes
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			clr_pend <= 1'b0;
		end else if (ce_i) begin
			if (clr_s2 != clr_prev) begin
				clr_pend <= 1'b1;                         // see RQ1
			end else if (cs_s2 && !cs_prev) begin
				clr_pend <= 1'b0;
			end
		end
	end

	// Write-enable latch; a set in the same cycle beats any clear
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			write_enable_latch <= 1'b0;                                  // see RQ2
		end else if (ce_i) begin
			if (wel_set_i) begin
				write_enable_latch <= 1'b1;
			end else if (clr_pend && cs_s2 && !cs_prev) begin
				write_enable_latch <= 1'b0;                              // see RQ1
			end else if (op_done_i) begin
				write_enable_latch <= 1'b0;                              // see RQ2
			end
		end
	end

	// Status write: needs latch, idle core and no hardware protection
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			stat1_nv         <= fsw_pkg::STAT1_RST[7:2];
			compl_q          <= fsw_pkg::STAT2_RST[fsw_pkg::COMPL_BIT];
			quad_q           <= fsw_pkg::STAT2_RST[fsw_pkg::QUAD_BIT];
			otp_q            <= fsw_pkg::STAT2_RST[fsw_pkg::OTP_A_BIT:fsw_pkg::OTP_C_BIT];
			stat_wr_start_o  <= 1'b0;
			stat_wr_reject_o <= 1'b0;
		end else if (ce_i) begin
			stat_wr_start_o  <= 1'b0;
			stat_wr_reject_o <= 1'b0;
			if (stat_wr_req_i) begin
				if (!write_enable_latch || busy_i || hw_protect) begin
					stat_wr_reject_o <= 1'b1;             // see RQ7 see RQ9 see RQ13
				end else begin
					stat_wr_start_o <= 1'b1;
					stat1_nv <= stat_wr_data1_i[7:2] & fsw_pkg::STAT1_WR_MASK[7:2];
					compl_q  <= stat_wr_data2_i[fsw_pkg::COMPL_BIT];
					quad_q   <= stat_wr_data2_i[fsw_pkg::QUAD_BIT];
					// Lock bits only ever go from 0 to 1
					otp_q <= otp_q | (stat_wr_data2_i[fsw_pkg::OTP_A_BIT:fsw_pkg::OTP_C_BIT]
						& fsw_pkg::STAT2_OTP_MASK[fsw_pkg::OTP_A_BIT:fsw_pkg::OTP_C_BIT]); // see RQ17
				end
			end
		end
	end

	// Array operation check
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			op_grant_o  <= 1'b0;
			op_reject_o <= 1'b0;
		end else if (ce_i) begin
			op_grant_o  <= 1'b0;
			op_reject_o <= 1'b0;
			if (op_req_i) begin
				if (!write_enable_latch || busy_i) begin
					op_reject_o <= 1'b1;                  // see RQ7
				end else if (op_kind_i == fsw_pkg::FSW_OP_CHIP) begin
					op_grant_o  <= level_zero(stat1_nv);   // see RQ10
					op_reject_o <= !level_zero(stat1_nv);
				end else if ((!level_zero(stat1_nv) && op_in_region_i)
						|| ((op_otp_hit_i & otp_q) != 3'h0)) begin
					op_reject_o <= 1'b1;                  // see RQ8 see RQ17
				end else begin
					op_grant_o <= 1'b1;
				end
			end
		end
	end

	// Link side: mode sync and status copy handshake
	always_ff @(posedge link_clk_i or posedge link_rst_q) begin
		if (link_rst_q) begin
			mode_s1 <= 1'b0;
			mode_s2 <= 1'b0;
			pub_s1  <= 1'b0;
			pub_s2  <= 1'b0;
			ack_q   <= 1'b0;
			copy1   <= fsw_pkg::STAT1_RST;
			copy2   <= fsw_pkg::STAT2_RST;
		end else begin
			mode_s1 <= four_line_cmd_mode_i;
			mode_s2 <= mode_s1;
			pub_s1  <= pub_tgl;
			pub_s2  <= pub_s1;
			if (pub_s2 != ack_q) begin
				copy1 <= pub1;                            // see RQ3
				copy2 <= pub2;
				ack_q <= pub_s2;
			end
		end
	end

	// Opcode bits this edge, one or four per clock
	always_comb begin
		next_in  = mode_s2 ? {in_sh[3:0], dq_i} : {in_sh, dq_i[0]}; // see RQ20
		last_cnt = mode_s2 ? fsw_pkg::LAST_QUAD : fsw_pkg::LAST_SINGLE;
	end

	// Latch-clear event toggle, kept across frames
	always_ff @(posedge link_clk_i or posedge link_rst_q) begin
		if (link_rst_q) begin
			clr_tgl <= 1'b0;
		end else if (!cs_n_i && !op_got && in_cnt == last_cnt
				&& next_in == fsw_pkg::OPC_LATCH_CLEAR) begin
			clr_tgl <= ~clr_tgl;                          // see RQ1
		end
	end

	// Opcode capture; frame state cleared by chip select
	always_ff @(posedge link_clk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			in_sh  <= 7'h00;
			in_cnt <= 3'h0;
			op_got <= 1'b0;
			rd_sel <= fsw_pkg::FSW_RD_NONE;
		end else if (!op_got) begin
			in_sh  <= next_in[6:0];
			in_cnt <= in_cnt + 3'h1;
			if (in_cnt == last_cnt) begin
				op_got <= 1'b1;
				// Decode the read opcodes
				if (next_in == fsw_pkg::OPC_STAT1_READ) begin
					rd_sel <= fsw_pkg::FSW_RD_STAT1;      // see RQ3
				end else if (next_in == fsw_pkg::OPC_STAT2_RD_A
						|| next_in == fsw_pkg::OPC_STAT2_RD_B) begin
					rd_sel <= fsw_pkg::FSW_RD_STAT2;      // see RQ14
				end else begin
					rd_sel <= fsw_pkg::FSW_RD_NONE;
				end
			end
		end
	end

	// Output shifter on falling edges, byte reloaded each round
	always_ff @(negedge link_clk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			obyte  <= 8'h00;
			oidx   <= 3'h0;
			out_on <= 1'b0;
		end else begin
			case (rd_sel)
				fsw_pkg::FSW_RD_STAT1, fsw_pkg::FSW_RD_STAT2: begin
					out_on <= 1'b1;
					if (oidx == 3'h0) begin
						// Fresh copy each byte so polling sees changes
						obyte <= (rd_sel == fsw_pkg::FSW_RD_STAT1) ? copy1 : copy2; // see RQ4
					end else if (mode_s2) begin
						obyte <= {obyte[3:0], 4'h0};      // see RQ20
					end else begin
						obyte <= {obyte[6:0], 1'b0};      // see RQ19
					end
					oidx <= (oidx == last_cnt) ? 3'h0 : oidx + 3'h1; // see RQ4
				end
				default: begin
					out_on <= 1'b0;
				end
			endcase
		end
	end

	// Pin drive: MSB on line 1, or top nibble on all four lines
	always_comb begin
		if (mode_s2) begin
			dq_o    = obyte[7:4];                         // see RQ20
			dq_oe_o = out_on ? 4'hf : 4'h0;
		end else begin
			dq_o    = {2'h0, obyte[7], 1'b0};             // see RQ19
			dq_oe_o = out_on ? 4'h2 : 4'h0;
		end
	end

endmodule : fsw_status_protect

//--- verification/fsw_status_protect_sva.sv
`timescale 1ns/1ns
module fsw_status_protect_sva (
	input  wire logic       clk_sys_i,
	input  wire logic       sys_rst_i,
	input  wire logic       ce_i,
	input  wire logic       cs_n_i,
	input  wire logic       wp_n_i,
	input  wire logic       busy_i,
	input  wire logic       erase_suspended_i,
	input  wire logic       program_suspended_i,
	input  wire logic       wel_set_i,
	input  wire logic       stat_wr_req_i,
	input  wire logic       op_req_i,
	input  wire logic [2:0] op_kind_i,
	input  wire logic       op_in_region_i,
	input  wire logic       op_done_i,
	input  wire logic [3:0] dq_oe_o,
	input  wire logic       stat_wr_start_o,
	input  wire logic       stat_wr_reject_o,
	input  wire logic       op_grant_o,
	input  wire logic       op_reject_o,
	input  wire logic [7:0] stat1_o,
	input  wire logic [7:0] stat2_o,
	input  wire logic       pin_functions_en_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	// Pin low long enough to pass its synchroniser
	sequence s_wp_low;
		!wp_n_i [*4];
	endsequence
	// Write request with lock armed and protect pin live
	sequence s_locked_wr;
		ce_i && stat_wr_req_i && stat1_o[7] && !stat2_o[1];
	endsequence
	a_busy_shown: assert property (stat1_o[0] == busy_i)
		else $error("busy flag differs from cycle input");
	a_susp_shown: assert property (stat2_o[7] == erase_suspended_i && stat2_o[2] == program_suspended_i)
		else $error("suspend flags differ from inputs");
	a_pins_quad: assert property (pin_functions_en_o == !stat2_o[1])
		else $error("pin functions do not follow quad enable");
	a_latch_refuse: assert property (ce_i && op_req_i && !stat1_o[1] |=> op_reject_o && !op_grant_o)
		else $error("operation taken with latch clear");
	a_chip_zero: assert property (ce_i && op_req_i && op_kind_i == 3'h5 && stat1_o[4:2] != 3'h0 |=> op_reject_o)
		else $error("chip erase taken with nonzero level");
	a_region_refuse: assert property (ce_i && op_req_i && op_kind_i < 3'h5 && stat1_o[4:2] != 3'h0 && op_in_region_i |=> op_reject_o)
		else $error("write into protected region taken");
	a_hw_freeze: assert property (s_wp_low ##0 s_locked_wr |=> stat_wr_reject_o && !stat_wr_start_o)
		else $error("status write taken under hardware protection");
	a_write_answer: assert property (ce_i && stat_wr_req_i |=> stat_wr_start_o ^ stat_wr_reject_o)
		else $error("status write not answered once");
	a_done_clears: assert property (ce_i && op_done_i && !wel_set_i |=> !stat1_o[1])
		else $error("latch survives completion");
	a_otp_sticky: assert property ((stat2_o[5:3] & $past(stat2_o[5:3])) == $past(stat2_o[5:3]))
		else $error("one-time lock bit cleared");
	a_oe_idle: assert property (cs_n_i [*2] |-> dq_oe_o == 4'h0)
		else $error("data lines driven while deselected");
endmodule : fsw_status_protect_sva
bind fsw_status_protect fsw_status_protect_sva i_sva (.clk_sys_i, .sys_rst_i, .ce_i, .cs_n_i,
	.wp_n_i, .busy_i, .erase_suspended_i, .program_suspended_i, .wel_set_i, .stat_wr_req_i,
	.op_req_i, .op_kind_i, .op_in_region_i, .op_done_i, .dq_oe_o, .stat_wr_start_o,
	.stat_wr_reject_o, .op_grant_o, .op_reject_o, .stat1_o, .stat2_o, .pin_functions_en_o);

//--- verification/fsw_host_model.sv
`timescale 1ns/1ns
module fsw_host_model (
	output logic            link_clk_o,
	output logic            cs_n_o,
	output logic      [3:0] dq_o,
	input  wire logic [3:0] dq_i
);
	// Clock rests low and select high between frames
	initial begin
		link_clk_o = 1'b0;
		cs_n_o     = 1'b1;
		dq_o       = 4'h5;
	end
	// One framed opcode, then nbits read clocks; quad moves a nibble per clock
	task automatic frame(input logic [7:0] opc, input int nbits, input logic quad,
		output logic [15:0] rx);
		rx = 16'h0000;
		cs_n_o = 1'b0;
		#8;
		for (int i = 7; i >= 0; i -= (quad ? 4 : 1)) begin
			if (quad)
				dq_o = opc[i -: 4];
			else
				dq_o[0] = opc[i];
			#7 link_clk_o = 1'b1;
			#8 link_clk_o = 1'b0;
		end
		for (int i = 0; i < nbits; i++) begin
			dq_o = ~dq_o; // Unused input keeps moving
			#7 link_clk_o = 1'b1;
			rx = quad ? {rx[11:0], dq_i} : {rx[14:0], dq_i[1]};
			#8 link_clk_o = 1'b0;
		end
		#8 cs_n_o = 1'b1;
		dq_o = ~dq_o;
		#30;
	endtask : frame
endmodule : fsw_host_model

//--- verification/testbench.sv
`timescale 1ns/1ns
module testbench;
	logic        clk_sys_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        wp_n      = 1'b1;
	logic        busy      = 1'b0;
	logic        esusp     = 1'b0;
	logic        psusp     = 1'b0;
	logic        wel_set   = 1'b0;
	logic        wr_req    = 1'b0;
	logic        op_req    = 1'b0;
	logic        op_done   = 1'b0;
	logic        in_reg    = 1'b0;
	logic  [7:0] wd1       = 8'h00;
	logic  [7:0] wd2       = 8'h00;
	logic  [2:0] kind      = 3'h0;
	logic  [2:0] otp       = 3'h0;
	logic        quad      = 1'b0;
	logic        lclk, cs_n, wr_ok, wr_no, grant, deny, pin_en;
	logic  [3:0] dq_h, dq_d, dq_oe;
	logic  [7:0] stat1, stat2;
	logic [15:0] rx;
	logic  [1:0] q_op[$];
	logic  [1:0] q_wr[$];
	int          fail_count = 0;
	int          compares   = 0;
	int unsigned r;
	// System clock
	always #5 clk_sys_i = ~clk_sys_i;
	fsw_status_protect i_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
		.link_clk_i(lclk), .cs_n_i(cs_n), .dq_i(dq_h), .dq_o(dq_d), .dq_oe_o(dq_oe),
		.wp_n_i(wp_n), .four_line_cmd_mode_i(quad), .busy_i(busy), .erase_suspended_i(esusp),
		.program_suspended_i(psusp), .wel_set_i(wel_set), .stat_wr_req_i(wr_req),
		.stat_wr_data1_i(wd1), .stat_wr_data2_i(wd2), .stat_wr_start_o(wr_ok),
		.stat_wr_reject_o(wr_no), .op_req_i(op_req), .op_kind_i(kind), .op_in_region_i(in_reg),
		.op_otp_hit_i(otp), .op_grant_o(grant), .op_reject_o(deny), .op_done_i(op_done),
		.stat1_o(stat1), .stat2_o(stat2), .pin_functions_en_o(pin_en));
	fsw_host_model i_host (.link_clk_o(lclk), .cs_n_o(cs_n), .dq_o(dq_h), .dq_i(dq_d));
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask : chk_byte
	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s answer: got %b expected %b", $time, what, got, exp);
		end
	endtask : chk_resp
	task automatic print_verdict;
		if (fail_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask : tick
	// Pair each answer pulse with the oldest note
	always @(posedge clk_sys_i) begin
		if (grant | deny)
			chk_resp({grant, deny}, q_op.size() ? q_op.pop_front() : 2'h0, "op");
		if (wr_ok | wr_no)
			chk_resp({wr_ok, wr_no}, q_wr.size() ? q_wr.pop_front() : 2'h0, "wr");
	end
	task automatic op(input logic [2:0] k, input logic hit, input logic [2:0] o, input logic ok);
		@(posedge clk_sys_i);
		kind <= k;
		in_reg <= hit;
		otp <= o;
		op_req <= 1'b1;
		q_op.push_back({ok, !ok});
		@(posedge clk_sys_i);
		op_req <= 1'b0;
		tick(2);
	endtask : op
	task automatic swr(input logic [7:0] d1, input logic [7:0] d2, input logic ok);
		@(posedge clk_sys_i);
		wd1 <= d1;
		wd2 <= d2;
		wr_req <= 1'b1;
		q_wr.push_back({ok, !ok});
		@(posedge clk_sys_i);
		wr_req <= 1'b0;
		tick(2);
	endtask : swr
	// Latch set, or completion when done is high
	task automatic pulse(input logic done);
		@(posedge clk_sys_i);
		if (done)
			op_done <= 1'b1;
		else
			wel_set <= 1'b1;
		@(posedge clk_sys_i);
		op_done <= 1'b0;
		wel_set <= 1'b0;
		tick(2);
	endtask : pulse
	task automatic rd(input logic [7:0] opc, input logic [7:0] exp);
		tick(20);
		// Flush frame lets the link copy catch up with the live status
		i_host.frame(8'hff, 16, quad, rx);
		i_host.frame(opc, quad ? 4 : 16, quad, rx);
		chk_byte(rx[15:8], exp, "link byte");
		chk_byte(rx[7:0], exp, "link repeat");
	endtask : rd
	// Hang guard
	initial begin
		#300000;
		fail_count++;
		print_verdict();
	end
	initial begin
		r = $urandom(9);
		tick(2);
		sys_rst_i <= 1'b0;
		tick(4);
		chk_byte(stat1, 8'h00, "stat1 reset");
		chk_byte(stat2, 8'h02, "stat2 reset");
		op(3'h2, 1'b0, 3'h0, 1'b0);
		swr(8'h00, 8'h02, 1'b0);
		pulse(1'b0);
		busy <= 1'b1;
		rd(fsw_pkg::OPC_STAT1_READ, 8'h03);
		op(3'h0, 1'b0, 3'h0, 1'b0);
		busy <= 1'b0;
		rd(fsw_pkg::OPC_STAT1_READ, 8'h02);
		i_host.frame(fsw_pkg::OPC_LATCH_CLEAR, 0, 1'b0, rx);
		tick(6);
		chk_byte(stat1, 8'h00, "after clear");
		pulse(1'b0);
		r = $urandom;
		swr(8'h1c | 8'(r & 3), 8'h40, 1'b1);
		chk_byte(stat1, 8'h1e, "level set");
		pulse(1'b1);
		chk_byte(stat1, 8'h1c, "after done");
		chk_byte({7'h00, pin_en}, 8'h01, "pins");
		rd(fsw_pkg::OPC_STAT2_RD_A, 8'h40);
		rd(fsw_pkg::OPC_STAT2_RD_B, 8'h40);
		pulse(1'b0);
		for (int k = 0; k < 6; k++)
			op(3'(k), 1'b1, 3'h0, 1'b0);
		op(3'h5, 1'b0, 3'h0, 1'b0);
		r = $urandom;
		op(3'(r % 5), 1'b0, 3'h0, 1'b1);
		swr(8'h9c, 8'h40, 1'b1);
		wp_n <= 1'b0;
		tick(4);
		swr(8'h00, 8'h40, 1'b0);
		chk_byte(stat1, 8'h9e, "frozen");
		wp_n <= 1'b1;
		tick(4);
		swr(8'h00, 8'h60, 1'b1);
		op(3'h0, 1'b0, 3'h4, 1'b0);
		op(3'h0, 1'b0, 3'h1, 1'b1);
		swr(8'h20, 8'h40, 1'b1);
		chk_byte(stat2, 8'h60, "lock kept");
		chk_byte(stat1, 8'h22, "bottom");
		op(3'h5, 1'b0, 3'h0, 1'b1);
		esusp <= 1'b1;
		psusp <= 1'b1;
		rd(fsw_pkg::OPC_STAT2_RD_B, 8'he4);
		esusp <= 1'b0;
		psusp <= 1'b0;
		tick(4);
		chk_byte(stat2, 8'h60, "resumed");
		quad <= 1'b1;
		rd(fsw_pkg::OPC_STAT1_READ, 8'h22);
		i_host.frame(fsw_pkg::OPC_LATCH_CLEAR, 0, 1'b1, rx);
		tick(6);
		chk_byte(stat1, 8'h20, "quad clear");
		chk_byte(8'(q_op.size() + q_wr.size()), 8'h00, "answers missing");
		print_verdict();
	end
endmodule : testbench
